// File: pkg/sac_pkg.sv
// Constants shared by the converter control logic.
// Assumes a single 20 MHz clock domain; all times are turned into cycle counts here.
package sac_pkg;
  localparam int          DATA_W        = 8;      // Width of the approximation register
  localparam int          CLK_PERIOD_NS = 50;     // Period of clk_in
  // Interval spent on each bit decision; eight of them stay near the usual conversion time
  localparam int          BIT_TIME_NS   = 3000;
  localparam int          BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Latest point at which data must be on the pins after the ready flag falls
  localparam int          DATA_LAG_NS   = 500;
  localparam int          DATA_LAG_CYC  = DATA_LAG_NS / CLK_PERIOD_NS;
  // Delay from request high to blanking of the outputs
  localparam int          RELEASE_NS    = 1500;
  localparam int          RELEASE_CYC   = RELEASE_NS / CLK_PERIOD_NS;
  // Least high time of the request line that re-arms the converter
  localparam int          ARM_NS        = 2000;
  localparam int          ARM_CYC       = (ARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CODE_RESET    = 8'h00;  // Register contents when idle
  localparam logic [7:0]  MSB_TRIAL     = 8'h80;  // First trial pattern
  localparam logic [7:0]  CNT_ZERO      = 8'h00;  // Counter reset value
endpackage

// File: pkg/sac_sar_if.sv
// Handshake between the control sequencer and the approximation register core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sac_sar_if #(parameter int DATA_W = 8);
  logic              start;       // One-cycle pulse: begin a conversion
  logic              abort;       // One-cycle pulse: drop conversion, clear register
  logic              comp_high;   // Synchronised comparator: DAC sum exceeds input
  logic              busy;        // Conversion in progress
  logic              done;        // One-cycle pulse: last bit decided
  logic [DATA_W-1:0] code;        // Present register contents
  modport ctrl (output start, output abort, output comp_high,
                input busy, input done, input code);
  modport core (input start, input abort, input comp_high,
                output busy, output done, output code);
endinterface

// File: src/sac_sar_core.sv
// Successive-approximation register with its per-bit pacing counter.
// Assumes the comparator decision is already synchronised to clk_in.
`timescale 1ns/1ps
module sac_sar_core #(
  parameter int DATA_W = sac_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Sequencer side
  sac_sar_if.core   sar
);
  logic [DATA_W-1:0] code_reg;   // Trial and result bits
  logic [2:0]        idx_reg;    // Bit under trial
  logic [7:0]        cnt_reg;    // Cycles spent on the present bit
  logic              busy_reg;   // Trial sequence running
  logic              done_reg;   // End-of-conversion pulse
  logic              decide;     // Last cycle of a bit interval
  logic [7:0]        gap_cnt_reg; // Check helper: cycles since last decision or start

  assign decide   = busy_reg && (cnt_reg == 8'(sac_pkg::BIT_CYCLES - 1));
  assign sar.code = code_reg;
  assign sar.busy = busy_reg;
  assign sar.done = done_reg;

  // Pacing counter: one equal interval per decision
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= sac_pkg::CNT_ZERO;
    end else if (sar.start || sar.abort || decide) begin
      cnt_reg <= sac_pkg::CNT_ZERO; // RULE_12
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Free-running gap measure for the pacing check; kept apart from cnt_reg so a
  // broken interval counter cannot hide behind its own value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_cnt_reg <= sac_pkg::CNT_ZERO;
    end else if (sar.start || decide) begin
      gap_cnt_reg <= sac_pkg::CNT_ZERO;
    end else if (gap_cnt_reg != 8'hFF) begin
      gap_cnt_reg <= gap_cnt_reg + 8'h01;
    end
  end

  // Trial sequence, most significant bit first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_reg <= sac_pkg::CODE_RESET;
      idx_reg  <= 3'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (sar.abort) begin
        // Abandoned or read out: clear ready for the next conversion
        code_reg <= sac_pkg::CODE_RESET; // RULE_04
        busy_reg <= 1'b0;
      end else if (sar.start) begin
        code_reg <= sac_pkg::MSB_TRIAL; // RULE_01
        idx_reg  <= 3'(DATA_W - 1);
        busy_reg <= 1'b1;
      end else if (decide) begin
        // Sum above input drops the bit, otherwise it stays on
        code_reg[idx_reg] <= !sar.comp_high; // RULE_02
        if (idx_reg == 3'h0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          code_reg[idx_reg - 3'h1] <= 1'b1; // RULE_01
          idx_reg                  <= idx_reg - 3'h1;
        end
      end
    end
  end

  a_first_trial_msb: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_01
    sar.start && !sar.abort |=> code_reg == sac_pkg::MSB_TRIAL && busy_reg)
    else $error("first trial is not the top bit alone");
  a_bit_kept_low: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_02
    decide && !sar.abort && !sar.start && !sar.comp_high |=> code_reg[$past(idx_reg)])
    else $error("bit dropped although the sum stayed below the input");
  a_bit_dropped_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_02
    decide && !sar.abort && !sar.start && sar.comp_high |=> !code_reg[$past(idx_reg)])
    else $error("bit kept although the sum exceeded the input");
  a_interval_equal: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_12
    decide |-> gap_cnt_reg == 8'(sac_pkg::BIT_CYCLES - 1))
    else $error("bit interval is not the pacing length");
  a_done_after_lsb: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_01
    done_reg |-> $past(idx_reg) == 3'h0 && !busy_reg)
    else $error("done raised before the lowest bit");
endmodule

// File: src/sac_top.sv
// Control and output logic of an 8-bit successive-approximation converter.
// Assumes request, strap and comparator arrive asynchronously on pins; the pad
// resolves data_out against data_oe_n_out (low means driven).
//
// Functional notes
// RULE_01 - Trial bits one at a time, MSB first
// RULE_02 - Keep bit unless DAC sum exceeds input
// RULE_03 - After last bit: ready low, drive data
// RULE_04 - Request high blanks outputs, clears register
// RULE_05 - Strap low unipolar, open gives bipolar
// RULE_06 - Bipolar codes offset binary, midscale is zero
// RULE_07 - Unipolar codes ascend in straight binary
// RULE_08 - Data active within 500 ns of ready
// RULE_09 - 1.5 us after request high: release
// RULE_10 - Two microseconds high re-arms, restarts conversion
// RULE_11 - Request high mid-conversion abandons, outputs unchanged
// RULE_12 - One equal clock interval per bit
`timescale 1ns/1ps
module sac_top #(
  parameter int DATA_W = sac_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Host request line, low starts a conversion once a long high has armed it
  input  wire logic              conv_req_n_in,
  // Coding strap: low unipolar, open (pulled high) bipolar
  input  wire logic              coding_strap_in,
  // Comparator: high when DAC sum exceeds input current
  input  wire logic              comp_high_in,
  // Analog side controls
  output logic [DATA_W-1:0]      dac_code_out,
  output logic                   bipolar_en_out,
  // Host side results
  output logic                   result_flag_n_out,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_VALID, ST_RELEASE} sac_state_type;

  sac_state_type     state_reg;       // Sequencer state
  logic [1:0]        req_sync_reg;    // Request synchroniser, bit 0 is the first stage
  logic [1:0]        strap_sync_reg;  // Strap synchroniser
  logic [1:0]        comp_sync_reg;   // Comparator synchroniser
  logic [7:0]        high_cnt_reg;    // Request high time
  logic [7:0]        rel_cnt_reg;     // Time spent releasing
  logic              armed_reg;       // Request was high long enough
  logic              flag_n_reg;      // Ready flag, active low
  logic              oe_n_reg;        // Data enable, low drives
  logic              bipolar_reg;     // Offset current switch
  logic [DATA_W-1:0] data_reg;        // Latched result
  logic              req_high;        // Request line is high (blank)
  logic              start_now;       // Conversion starts this cycle
  logic              release_now;     // Blanking delay has run out

  sac_sar_if #(.DATA_W(DATA_W)) sar ();

  sac_sar_core #(.DATA_W(DATA_W)) u_core (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .sar      (sar)
  );

  assign req_high    = req_sync_reg[1];
  assign start_now   = (state_reg == ST_IDLE) && !req_high && armed_reg;
  assign release_now = (state_reg == ST_RELEASE) && req_high &&
                       (rel_cnt_reg == 8'(sac_pkg::RELEASE_CYC - 1));
  assign sar.start     = start_now;
  // Abandon mid-conversion, or clear after readout
  assign sar.abort     = ((state_reg == ST_CONV) && req_high) || release_now; // RULE_11
  assign sar.comp_high = comp_sync_reg[1];

  assign dac_code_out      = sar.code;
  assign bipolar_en_out    = bipolar_reg;
  assign result_flag_n_out = flag_n_reg;
  assign data_out          = data_reg;
  assign data_oe_n_out     = oe_n_reg;

  // Pin synchronisers; only the second stage is read by logic
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_sync_reg   <= 2'h3;
      strap_sync_reg <= 2'h0;
      comp_sync_reg  <= 2'h0;
    end else begin
      req_sync_reg   <= {req_sync_reg[0], conv_req_n_in};
      strap_sync_reg <= {strap_sync_reg[0], coding_strap_in};
      comp_sync_reg  <= {comp_sync_reg[0], comp_high_in};
    end
  end

  // High-time measure; a short glitch high does not re-arm
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_cnt_reg <= sac_pkg::CNT_ZERO;
      armed_reg    <= 1'b0;
    end else begin
      if (!req_high) begin
        high_cnt_reg <= sac_pkg::CNT_ZERO;
      end else if (high_cnt_reg != 8'(sac_pkg::ARM_CYC)) begin
        high_cnt_reg <= high_cnt_reg + 8'h01;
      end
      if (start_now) begin
        armed_reg <= 1'b0;
      end else if (req_high && high_cnt_reg == 8'(sac_pkg::ARM_CYC - 1)) begin
        armed_reg <= 1'b1; // RULE_10
      end
    end
  end

  // Coding selection, held steady for a whole conversion
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bipolar_reg <= 1'b0;
    end else if (start_now) begin
      // Offset current makes the same register read as offset binary
      bipolar_reg <= strap_sync_reg[1]; // RULE_05
    end
  end

  // Sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_now) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (req_high) begin
            state_reg <= ST_IDLE; // RULE_11
          end else if (sar.done) begin
            state_reg <= ST_VALID;
          end
        end
        ST_VALID: begin
          if (req_high) begin
            state_reg <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!req_high) begin
            state_reg <= ST_VALID; // Short high: keep showing data
          end else if (release_now) begin
            state_reg <= ST_IDLE; // RULE_04
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Blanking delay counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_cnt_reg <= sac_pkg::CNT_ZERO;
    end else if (state_reg == ST_RELEASE && req_high) begin
      rel_cnt_reg <= rel_cnt_reg + 8'h01; // RULE_09
    end else begin
      rel_cnt_reg <= sac_pkg::CNT_ZERO;
    end
  end

  // Result capture and ready flag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_n_reg <= 1'b1;
      data_reg   <= sac_pkg::CODE_RESET;
    end else if (state_reg == ST_CONV && !req_high && sar.done) begin
      // Register bits pass straight through; coding comes from the strap
      flag_n_reg <= 1'b0; // RULE_03
      data_reg   <= sar.code; // RULE_06 RULE_07
    end else if (release_now) begin
      flag_n_reg <= 1'b1; // RULE_09
    end
  end

  // Output enable falls one cycle after the flag, well inside the limit, and rises with it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_n_reg <= 1'b1;
    end else if (release_now) begin
      oe_n_reg <= 1'b1; // RULE_04
    end else if (state_reg == ST_VALID) begin
      oe_n_reg <= 1'b0; // RULE_08
    end
  end

  localparam int LAG_MAX = sac_pkg::DATA_LAG_CYC;
  // A start only follows a full arm count, so the high counter sits saturated there
  localparam logic [7:0] CNT_AT_START = 8'(sac_pkg::ARM_CYC);

  a_flag_on_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_reg == ST_CONV && !req_high && sar.done |=> !flag_n_reg) // RULE_03
    else $error("ready flag did not fall after the last bit");
  a_data_after_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(flag_n_reg) |-> ##[0:LAG_MAX] !oe_n_reg) // RULE_08
    else $error("data not driven in time after ready");
  a_drive_with_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !oe_n_reg |-> !flag_n_reg && $stable(data_reg)) // RULE_03
    else $error("data driven without ready or changing while driven");
  a_release_timing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(flag_n_reg) |-> $past(rel_cnt_reg) == 8'(sac_pkg::RELEASE_CYC - 1)
      && oe_n_reg && dac_code_out == sac_pkg::CODE_RESET) // RULE_09
    else $error("release not at the blanking delay");
  a_blank_with_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(oe_n_reg) |-> $rose(flag_n_reg)) // RULE_04
    else $error("outputs released without raising ready");
  a_abandon_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_reg == ST_CONV && req_high |=> flag_n_reg && oe_n_reg && state_reg == ST_IDLE) // RULE_11
    else $error("abandoned conversion disturbed the outputs");
  a_start_armed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    start_now |-> $past(req_high) && high_cnt_reg == CNT_AT_START) // RULE_10
    else $error("conversion started without a long enough high");
  a_coding_latched: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    start_now |=> bipolar_reg == $past(strap_sync_reg[1])) // RULE_05
    else $error("coding select not taken from the strap");

  c_full_cycle: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(flag_n_reg));
  c_abandon: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state_reg == ST_CONV && req_high);
  c_bipolar_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(flag_n_reg) && bipolar_reg);
endmodule

// File: dv/sac_host_model.sv
// Host model that owns the converter request line and reads results.
// Assumes the testbench calls its tasks from one process, on the falling edge.
`timescale 1ns/1ps
module sac_host_model (
  // Clock
  input  wire logic       clk_in,
  // Device results
  input  wire logic       result_flag_n_in,
  input  wire logic [7:0] data_in,
  input  wire logic       data_oe_n_in,
  // Request line, low asks for a conversion
  output logic            conv_req_n_out
);
  // Idle host keeps the line high so the device can arm
  initial conv_req_n_out = 1'b1;

  // Raise the line for a number of cycles; long highs blank and re-arm
  task automatic hold_high(input int cyc);
    @(negedge clk_in);
    conv_req_n_out = 1'b1;
    repeat (cyc) @(negedge clk_in);
  endtask

  // Lower the line, wait (bounded) for the flag, then for the enabled data
  task automatic convert(input int limit, output int cyc, output logic [7:0] code,
                         output int lag);
    cyc = 0;
    lag = 0;
    conv_req_n_out = 1'b0;
    while (result_flag_n_in !== 1'b0 && cyc < limit) begin
      @(negedge clk_in);
      cyc++;
    end
    // A stuck enable is cut off here; the caller sees a lag out of range
    while (data_oe_n_in !== 1'b0 && lag < 20) begin
      @(negedge clk_in);
      lag++;
    end
    code = data_in;
  endtask
endmodule

// File: dv/tb_sar_adc_control_8bit.sv
// Self-checking bench for the converter control block.
// Assumes the 60-cycle bit interval and 30/40-cycle blank and arm delays of the design.
`timescale 1ns/1ps
module tb_sar_adc_control_8bit;
  logic       clk_in, rst_n_in, conv_req_n, coding_strap_in, comp_high_in;
  logic [7:0] dac_code_out, data_out, code;
  logic       bipolar_en_out, result_flag_n_out, data_oe_n_out;
  int         mismatches, checks_done, vin, cyc, lag, n;
  bit         bip;
  logic [7:0] exp_q[$];  // Expected codes, popped at each result of the main loop

  sac_top #(.DATA_W(8)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .conv_req_n_in(conv_req_n), .coding_strap_in(coding_strap_in),
    .comp_high_in(comp_high_in), .dac_code_out(dac_code_out),
    .bipolar_en_out(bipolar_en_out), .result_flag_n_out(result_flag_n_out),
    .data_out(data_out), .data_oe_n_out(data_oe_n_out));
  sac_host_model host (.clk_in(clk_in), .result_flag_n_in(result_flag_n_out),
    .data_in(data_out), .data_oe_n_in(data_oe_n_out), .conv_req_n_out(conv_req_n));

  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Comparator: high when the DAC sum, less the offset in bipolar mode, exceeds the input
  always @(negedge clk_in) begin
    comp_high_in <= (int'(dac_code_out) - ((bipolar_en_out === 1'b1) ? 128 : 0)) > vin;
  end

  // Reference conversion: keep each trial bit unless it overshoots the input
  function automatic logic [7:0] model_code(input int v, input bit bp);
    int acc;
    int trial;
    acc = 0;
    for (int b = 7; b >= 0; b--) begin
      trial = acc + (1 << b);
      if (trial - (bp ? 128 : 0) <= v) acc = trial;
    end
    return acc[7:0];
  endfunction

  task automatic chk_code(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_range(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One full conversion at the present input and strap
  task automatic run_conv(input logic [7:0] e);
    host.convert(600, cyc, code, lag);
    chk_range("conv_cycles", 480, 495, cyc);
    chk_range("data_lag", 0, 10, lag);
    chk_code("result", e, code);
    chk_bit("bipolar", bip, bipolar_en_out);
  endtask

  int vt[8] = '{0, 1, 254, 255, 128, -128, 0, 127};  // Edge inputs of both ranges
  initial begin
    rst_n_in = 1'b0;
    coding_strap_in = 1'b0;
    vin = 0;
    void'($urandom(50));
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk_bit("flag_reset", 1'b1, result_flag_n_out);
    chk_bit("oe_reset", 1'b1, data_oe_n_out);
    chk_code("dac_reset", 8'h00, dac_code_out);
    // A low without a prior long high must be ignored
    host.convert(300, cyc, code, lag);
    chk_range("unarmed", 300, 300, cyc);
    for (int i = 0; i < 14; i++) begin
      bip = (i < 8) ? (i >= 5) : $urandom_range(1, 0);
      vin = (i < 8) ? vt[i] : int'($urandom_range(255, 0)) - (bip ? 128 : 0);
      host.hold_high(45);
      coding_strap_in = bip;
      exp_q.push_back(model_code(vin, bip));
      run_conv(exp_q.pop_front());
      if (i % 2 == 0) begin
        // Short high while the result shows keeps it shown
        host.hold_high(10);
        host.convert(5, cyc, code, lag);
        chk_bit("short_high_oe", 1'b0, data_oe_n_out);
        chk_code("short_high_data", model_code(vin, bip), data_out);
      end
      host.hold_high(25);
      chk_bit("flag_hold", 1'b0, result_flag_n_out);
      n = 0;
      while (result_flag_n_out !== 1'b1 && n < 30) begin
        @(negedge clk_in);
        n++;
      end
      chk_range("release", 2, 12, n);
      chk_bit("oe_release", 1'b1, data_oe_n_out);
      chk_code("dac_clear", 8'h00, dac_code_out);
    end
    // Abandon a conversion half way, then restart after a long high
    bip = 1'b0;
    vin = 200;
    host.hold_high(45);
    coding_strap_in = 1'b0;
    host.convert(200, cyc, code, lag);
    host.hold_high(45);
    chk_bit("abort_flag", 1'b1, result_flag_n_out);
    chk_bit("abort_oe", 1'b1, data_oe_n_out);
    run_conv(model_code(vin, bip));
    // Reset in mid-conversion: outputs idle, device unarmed until a long high
    host.hold_high(45);
    host.convert(100, cyc, code, lag);
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk_bit("flag_rst2", 1'b1, result_flag_n_out);
    chk_bit("oe_rst2", 1'b1, data_oe_n_out);
    chk_code("dac_rst2", 8'h00, dac_code_out);
    host.hold_high(45);
    run_conv(model_code(vin, bip));
    close_out();
  end
endmodule
